// ===== cau_pkg.sv
// shared constants for the csr access unit
package cau_pkg;

    // instruction field positions
    localparam int          CSR_ADDR_MSB   = 31;
    localparam int          CSR_ADDR_LSB   = 20;
    localparam int          RS1_MSB        = 19;
    localparam int          RS1_LSB        = 15;
    localparam int          FUNCT3_MSB     = 14;
    localparam int          FUNCT3_LSB     = 12;
    localparam int          RD_MSB         = 11;
    localparam int          RD_LSB         = 7;
    localparam int          OPCODE_MSB     = 6;
    localparam int          OPCODE_LSB     = 0;

    localparam logic [6:0]  OPCODE_SYSTEM  = 7'h73;

    // function codes of the six csr instructions
    localparam logic [2:0]  F3_RW          = 3'h1;
    localparam logic [2:0]  F3_RS          = 3'h2;
    localparam logic [2:0]  F3_RC          = 3'h3;
    localparam logic [2:0]  F3_RWI         = 3'h5;
    localparam logic [2:0]  F3_RSI         = 3'h6;
    localparam logic [2:0]  F3_RCI         = 3'h7;

    // csr addresses
    localparam logic [11:0] ADDR_MACHINE_STATUS = 12'h300;
    localparam logic [11:0] ADDR_ISA_EXT_INFO   = 12'h301;

    // machine width field encodings and position
    localparam logic [1:0]  MW_RESERVED    = 2'h0;
    localparam logic [1:0]  MW_32          = 2'h1;
    localparam logic [1:0]  MW_64          = 2'h2;
    localparam logic [1:0]  MW_128         = 2'h3;
    localparam logic [1:0]  MW_RESET       = MW_32;
    localparam int          MW_MSB         = 31;
    localparam int          MW_LSB         = 30;

    // extension bits: one per letter from bit 0
    localparam int          EXT_C_BIT      = 2;
    localparam int          EXT_E_BIT      = 4;
    localparam int          EXT_M_BIT      = 12;
    localparam logic [25:0] EXT_BITS_VALUE = 26'h0001014;

    // machine status fields kept by this core
    localparam int          MS_IE_BIT      = 3;
    localparam int          MS_PREV_IE_BIT = 7;
    localparam int          MS_PMODE_MSB   = 12;
    localparam int          MS_PMODE_LSB   = 11;
    localparam logic [1:0]  MS_PMODE_MACH  = 2'h3;
    localparam logic [31:0] MS_WRITE_MASK  = 32'h00000088;
    localparam logic [31:0] MS_RESET       = 32'h00001800;

    // number of general purpose registers, index width
    localparam int          GPR_COUNT      = 16;
    localparam int          GPR_IDX_W      = 4;

    // operation kinds after decoding
    typedef enum logic [1:0] {
        CAU_OP_WRITE = 2'h0,
        CAU_OP_SET   = 2'h1,
        CAU_OP_CLEAR = 2'h2
    } cau_op_e;

    // handshake states, one-hot
    typedef enum logic [1:0] {
        CAU_ST_IDLE  = 2'b01,
        CAU_ST_REPLY = 2'b10
    } cau_state_e;

endpackage : cau_pkg

// ===== cau_decode.sv
// field decoder for the csr access instructions
`timescale 1ns/1ps
`default_nettype none
module cau_decode (
    input  wire logic [31:0]       instr,
    output logic      [11:0]       csr_addr,
    output logic      [4:0]        src_field,
    output logic      [4:0]        dst_field,
    output cau_pkg::cau_op_e       op_kind,
    output logic                   imm_form,
    output logic                   is_csr_op
);
    import cau_pkg::*;

    logic [2:0] funct3;
    logic [6:0] opcode;

    // plain field slicing
    assign csr_addr  = instr[CSR_ADDR_MSB:CSR_ADDR_LSB]; // RULE6
    assign src_field = instr[RS1_MSB:RS1_LSB]; // RULE6
    assign dst_field = instr[RD_MSB:RD_LSB]; // RULE6
    assign funct3    = instr[FUNCT3_MSB:FUNCT3_LSB]; // RULE6
    assign opcode    = instr[OPCODE_MSB:OPCODE_LSB]; // RULE6

    // function code to operation; codes 000 and 100 are not csr accesses
    always_comb begin
        op_kind   = CAU_OP_WRITE;
        imm_form  = 1'b0;
        is_csr_op = (opcode == OPCODE_SYSTEM);
        case (funct3)
            F3_RW:   op_kind = CAU_OP_WRITE;
            F3_RS:   op_kind = CAU_OP_SET;
            F3_RC:   op_kind = CAU_OP_CLEAR;
            F3_RWI: begin
                op_kind  = CAU_OP_WRITE;
                imm_form = 1'b1; // RULE5
            end
            F3_RSI: begin
                op_kind  = CAU_OP_SET;
                imm_form = 1'b1; // RULE5
            end
            F3_RCI: begin
                op_kind  = CAU_OP_CLEAR;
                imm_form = 1'b1; // RULE5
            end
            default: is_csr_op = 1'b0;
        endcase
    end
endmodule : cau_decode
`default_nettype wire

// ===== cau_merge.sv
// computes the raw new csr value from old value, operand and operation
`timescale 1ns/1ps
`default_nettype none
module cau_merge (
    input  wire logic [31:0]       old_value,
    input  wire logic [31:0]       operand,
    input  wire cau_pkg::cau_op_e  op_kind,
    output logic      [31:0]       new_value
);
    import cau_pkg::*;

    // writable-bit masking is applied later by the legaliser
    always_comb begin
        case (op_kind)
            CAU_OP_WRITE: new_value = operand; // RULE1
            CAU_OP_SET:   new_value = old_value | operand; // RULE2
            CAU_OP_CLEAR: new_value = old_value & ~operand; // RULE3
            default:      new_value = old_value;
        endcase
    end
endmodule : cau_merge
`default_nettype wire

// ===== csr_access_unit.sv
// csr access unit: decodes and executes csr instructions on two machine csrs
//
// How it works
// RULE1: read-write returns old value, loads source
// RULE2: read-set returns old, sets selected writable bits
// RULE3: read-clear returns old, clears selected writable bits
// RULE4: set/clear with x0 source never modifies
// RULE5: immediate forms use zero-extended 5-bit field
// RULE6: decode csr, source, function, destination, opcode fields
// RULE7: plain read/write are aliases, no special path
// RULE8: width field 01/10/11 means 32/64/128 bits
// RULE9: width field resets to 32 bits
// RULE10: width field in top two bits
// RULE11: extension bits report E, C, M
// RULE12: sixteen registers, machine mode only
// RULE13: unprovided reserved fields read zero
// RULE14: software writes only legal encodings there
// RULE15: illegal write-any values never trap
// RULE16: illegal writes read back deterministic legal value
// RULE17: status at 0x300, isa info at 0x301
// RULE18: unimplemented csr address raises illegal instruction
`timescale 1ns/1ps
`default_nettype none
module csr_access_unit (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        csr_req,
    input  wire logic [31:0] csr_instr,
    input  wire logic [31:0] src_value,
    output logic             csr_ready,
    output logic             csr_done,
    output logic             illegal_instr,
    output logic             dest_write,
    output logic [4:0]       dest_index,
    output logic [31:0]      dest_value,
    output logic             machine_ie,
    output logic [1:0]       machine_width
);
    import cau_pkg::*;

    // decoded instruction
    logic [11:0] csr_addr;
    logic [4:0]  src_field;
    logic [4:0]  dst_field;
    cau_op_e     op_kind;
    logic        imm_form;
    logic        is_csr_op;

    cau_decode u_decode (
        .instr     (csr_instr),
        .csr_addr  (csr_addr),
        .src_field (src_field),
        .dst_field (dst_field),
        .op_kind   (op_kind),
        .imm_form  (imm_form),
        .is_csr_op (is_csr_op)
    );

    // architectural state
    cau_state_e  state_reg,       state_next;
    logic [31:0] status_reg,      status_next;
    logic [1:0]  width_reg,       width_next;
    logic        ready_reg,       ready_next;
    logic        done_reg,        done_next;
    logic        illegal_reg,     illegal_next;
    logic        dwrite_reg,      dwrite_next;
    logic [4:0]  dindex_reg,      dindex_next;
    logic [31:0] dvalue_reg,      dvalue_next;

    // read views of the two csrs
    logic [31:0] status_view;
    logic [31:0] isa_view;
    logic [31:0] old_value;
    logic [31:0] operand;
    logic [31:0] raw_value;
    logic        addr_status;
    logic        addr_isa;
    logic        gpr_bad;
    logic        no_modify;
    logic        take;

    // only the kept status bits exist; everything else is hardwired zero
    assign status_view = status_reg & (MS_WRITE_MASK | MS_RESET); // RULE13
    // width field on top, fixed extension letters, reserved middle reads zero
    assign isa_view = {width_reg, 4'h0, EXT_BITS_VALUE}; // RULE10 RULE11 RULE13

    assign addr_status = (csr_addr == ADDR_MACHINE_STATUS); // RULE17
    assign addr_isa    = (csr_addr == ADDR_ISA_EXT_INFO); // RULE17
    assign old_value   = addr_isa ? isa_view : status_view;

    // immediate is zero-extended; register form takes the source value
    assign operand = imm_form ? {27'h0000000, src_field} : src_value; // RULE5

    // an embedded-base core only has x0..x15 to name
    assign gpr_bad = dst_field[GPR_IDX_W] | (~imm_form & src_field[GPR_IDX_W]); // RULE12

    // set/clear with a zero source field only read; plain read falls out here
    assign no_modify = (op_kind != CAU_OP_WRITE) && (src_field == 5'h00); // RULE4 RULE7

    assign take = csr_req & (state_reg == CAU_ST_IDLE);

    cau_merge u_merge (
        .old_value (old_value),
        .operand   (operand),
        .op_kind   (op_kind),
        .new_value (raw_value)
    );

    // next-state: execute one request, answer it in the following cycle
    always_comb begin
        state_next   = state_reg;
        status_next  = status_reg;
        width_next   = width_reg;
        ready_next   = ready_reg;
        done_next    = 1'b0;
        illegal_next = 1'b0;
        dwrite_next  = 1'b0;
        dindex_next  = dindex_reg;
        dvalue_next  = dvalue_reg;
        case (state_reg)
            CAU_ST_IDLE: begin
                if (take) begin
                    state_next  = CAU_ST_REPLY;
                    ready_next  = 1'b0;
                    done_next   = 1'b1;
                    dindex_next = dst_field;
                    if (!is_csr_op || gpr_bad || !(addr_status || addr_isa)) begin
                        illegal_next = 1'b1; // RULE18
                        dvalue_next  = 32'h00000000;
                    end else begin
                        // old value goes back, destination x0 writes nothing
                        dvalue_next = old_value; // RULE1 RULE2 RULE3 RULE7
                        dwrite_next = (dst_field != 5'h00); // RULE7
                        if (!no_modify) begin
                            if (addr_status) begin
                                // only writable bits move; machine mode pinned
                                status_next = (raw_value & MS_WRITE_MASK) | MS_RESET; // RULE2 RULE3 RULE12 RULE16
                            end else if (raw_value[MW_MSB:MW_LSB] == MW_32) begin
                                width_next = MW_32; // RULE8
                            end else begin
                                // unsupported width: keep old value, no trap
                                width_next = width_reg; // RULE15 RULE16
                            end
                        end
                    end
                end
            end
            CAU_ST_REPLY: begin
                state_next = CAU_ST_IDLE;
                ready_next = 1'b1;
            end
            default: begin
                state_next = CAU_ST_IDLE;
                ready_next = 1'b1;
            end
        endcase
    end

    // registers; width field starts at 32 bits, the only width this core supports
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg   <= CAU_ST_IDLE;
            status_reg  <= MS_RESET;
            width_reg   <= MW_RESET; // RULE9
            ready_reg   <= 1'b1;
            done_reg    <= 1'b0;
            illegal_reg <= 1'b0;
            dwrite_reg  <= 1'b0;
            dindex_reg  <= 5'h00;
            dvalue_reg  <= 32'h00000000;
        end else begin
            state_reg   <= state_next;
            status_reg  <= status_next;
            width_reg   <= width_next;
            ready_reg   <= ready_next;
            done_reg    <= done_next;
            illegal_reg <= illegal_next;
            dwrite_reg  <= dwrite_next;
            dindex_reg  <= dindex_next;
            dvalue_reg  <= dvalue_next;
        end
    end

    // outputs straight from flip-flops
    assign csr_ready     = ready_reg;
    assign csr_done      = done_reg;
    assign illegal_instr = illegal_reg;
    assign dest_write    = dwrite_reg;
    assign dest_index    = dindex_reg;
    assign dest_value    = dvalue_reg;
    assign machine_ie    = status_reg[MS_IE_BIT];
    assign machine_width = width_reg;

endmodule : csr_access_unit
`default_nettype wire

// ===== cau_properties.sv
// assertion checker for the csr access unit ports
`timescale 1ns/1ps
`default_nettype none
module cau_properties (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        csr_req,
    input wire logic [31:0] csr_instr,
    input wire logic [31:0] src_value,
    input wire logic        csr_ready,
    input wire logic        csr_done,
    input wire logic        illegal_instr,
    input wire logic        dest_write,
    input wire logic [4:0]  dest_index,
    input wire logic [31:0] dest_value,
    input wire logic        machine_ie,
    input wire logic [1:0]  machine_width
);
    import cau_pkg::*;
    logic take;
    logic ok;
    logic rw_bit;
    // a taken request, and whether every field is one this core accepts
    assign take = csr_req && csr_ready;
    assign ok = csr_instr[6:0] == OPCODE_SYSTEM && csr_instr[13:12] != 2'h0
        && !csr_instr[11] && (csr_instr[14] || !csr_instr[19])
        && csr_instr[31:21] == 11'h180;
    // enable bit a write should load: immediate bit 3 or operand bit 3
    assign rw_bit = csr_instr[14] ? csr_instr[18] : src_value[3];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_done_follows: assert property (take |=> csr_done)
        else $error("no answer one cycle after a taken request");
    a_no_stray_done: assert property (!take |=> !csr_done)
        else $error("answer without a taken request");
    a_bad_addr_trap: assert property (take && csr_instr[31:21] != 11'h180 |=> illegal_instr && !dest_write)
        else $error("unimplemented address not rejected");
    a_legal_no_trap: assert property (take && ok |=> !illegal_instr)
        else $error("legal access rejected");
    a_x0_no_write: assert property (take && csr_instr[13] && csr_instr[19:15] == 5'h0 |=> $stable(machine_ie))
        else $error("set or clear with zero source changed the status");
    a_rw_loads: assert property (take && ok && csr_instr[13:12] == 2'h1 && !csr_instr[20] |=> machine_ie == $past(rw_bit))
        else $error("write did not load the enable bit");
    a_isa_value: assert property (take && ok && csr_instr[20] |=> dest_value == 32'h40001014)
        else $error("isa register read wrong");
    a_width_32: assert property (machine_width == 2'h1)
        else $error("width field not 32 bits");
    c_write: cover property (take && ok && csr_instr[13:12] == 2'h1);
    c_trap: cover property (illegal_instr);
    c_x0: cover property (take && ok && csr_instr[13] && csr_instr[19:15] == 5'h0);
endmodule : cau_properties
bind csr_access_unit cau_properties chk_u (.ref_clk, .sys_rst, .csr_req, .csr_instr,
    .src_value, .csr_ready, .csr_done, .illegal_instr, .dest_write, .dest_index,
    .dest_value, .machine_ie, .machine_width);
`default_nettype wire

// ===== cau_pipe_model.sv
// execute pipeline model: presents csr requests and holds them until taken
`timescale 1ns/1ps
`default_nettype none
module cau_pipe_model (
    input  wire logic        ref_clk,
    input  wire logic        csr_ready,
    output var  logic        csr_req,
    output var  logic [31:0] csr_instr,
    output var  logic [31:0] src_value
);
    initial begin
        csr_req = 1'b0;
        csr_instr = 32'h0;
        src_value = 32'h0;
    end
    // hold until ready is seen high; idle lines show inverted data so stale values never pass
    task automatic issue(input logic [31:0] ins, input logic [31:0] src);
        @(posedge ref_clk);
        #1;
        csr_req = 1'b1;
        csr_instr = ins;
        src_value = src;
        @(posedge ref_clk);
        while (!csr_ready) @(posedge ref_clk);
        #1;
        csr_req = 1'b0;
        csr_instr = ~ins;
        src_value = ~src;
    endtask : issue
endmodule : cau_pipe_model
`default_nettype wire

// ===== csr_access_unit_test.sv
// self-checking bench for the csr access unit
`timescale 1ns/1ps
`default_nettype none
module csr_access_unit_test;
    import cau_pkg::*;
    logic        ref_clk, sys_rst, csr_req, csr_ready, csr_done, illegal_instr;
    logic        dest_write, machine_ie;
    logic [31:0] csr_instr, src_value, dest_value, ins;
    logic [4:0]  dest_index;
    logic [1:0]  machine_width;
    int          bad_count = 0;
    int          checked = 0;
    int          ms_m;
    csr_access_unit dut_u (.ref_clk, .sys_rst, .csr_req, .csr_instr, .src_value,
        .csr_ready, .csr_done, .illegal_instr, .dest_write, .dest_index, .dest_value,
        .machine_ie, .machine_width);
    cau_pipe_model pm_u (.ref_clk, .csr_ready, .csr_req, .csr_instr, .src_value);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] enc(input logic [11:0] a, input logic [4:0] s,
        input logic [2:0] f, input logic [4:0] d);
        return {a, s, f, d, OPCODE_SYSTEM};
    endfunction : enc
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // model works the old value and new status, then compares the answer cycle
    task automatic run(input logic [31:0] i, input logic [31:0] s);
        int   old;
        int   opv;
        int   nv;
        logic ok;
        ok = i[6:0] == 7'h73 && i[13:12] != 2'h0 && !i[11] && (i[14] || !i[19])
            && i[31:21] == 11'h180;
        old = ok ? (i[20] ? 32'h40001014 : ms_m) : 0;
        opv = i[14] ? int'(i[19:15]) : int'(s);
        case (i[13:12])
            2'h1: nv = opv;
            2'h2: nv = old | opv;
            default: nv = old & ~opv;
        endcase
        if (ok && !i[20] && !(i[13] && i[19:15] == 5'h0)) ms_m = (ms_m & ~32'h88) | (nv & 32'h88);
        pm_u.issue(i, s);
        // the answer stands only in the cycle after the taking edge, so look there
        #1;
        check(csr_done, 1);
        check(illegal_instr, !ok);
        check(dest_write, ok && i[11:7] != 0);
        check(dest_value, old);
        if (ok) check(dest_index, i[11:7]);
        check(machine_ie, ms_m[3]);
        check(machine_width, 1);
    endtask : run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    // cut a hang short well past the expected few hundred cycles
    initial begin
        #(25 * 3000);
        bad_count++;
        print_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        void'($urandom(94));
        repeat (3) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        ms_m = 32'h1800;
        #1;
        check(csr_ready, 1);
        check(machine_width, 1);
        run(enc(12'h301, 5'h0, 3'h2, 5'h5), 32'h0);
        run(enc(12'h300, 5'h0, 3'h2, 5'h6), 32'h0);
        run(enc(12'h300, 5'h0, 3'h3, 5'h1), 32'hFFFFFFFF);
        run(enc(12'h301, 5'h3, 3'h1, 5'h0), 32'h0);
        run(enc(12'h301, 5'h0, 3'h2, 5'h2), 32'h0);
        for (int k = 0; k < 96; k++) begin
            ins = enc(12'h300 | 12'(k % 2), 5'($urandom), 3'(k / 2), 5'($urandom % 16));
            run(ins, $urandom);
        end
        for (int k = 0; k < 40; k++) begin
            ins = enc(12'($urandom), 5'($urandom), 3'($urandom), 5'($urandom));
            run(k % 4 ? ins : $urandom, $urandom);
        end
        run(enc(12'h300, 5'h8, 3'h5, 5'h0), 32'h0);
        @(posedge ref_clk);
        #1 sys_rst = 1'b1;
        @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        ms_m = 32'h1800;
        run(enc(12'h300, 5'h0, 3'h2, 5'h7), 32'h0);
        print_verdict();
    end
endmodule : csr_access_unit_test
`default_nettype wire
